// [hw/serial_tx_empty_status.sv]
`timescale 1ns/10ps
module serial_tx_empty_status (
  input wire logic pclk, // System clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, 1 = write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  output logic txd, // Serial transmit line
  output logic tx_empty_irq, // Transmit-register-empty request
  output logic irq // Combined sticky interrupt
);

  // Word index decode, shared by setup capture and access effects
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, serial_tx_pkg::IDX_FORMAT)
      || hit(addr, serial_tx_pkg::IDX_DIVISOR)
      || hit(addr, serial_tx_pkg::IDX_CONTROL)
      || hit(addr, serial_tx_pkg::IDX_TX_HOLD)
      || hit(addr, serial_tx_pkg::IDX_FLAGS)
      || hit(addr, serial_tx_pkg::IDX_RX_HOLD)
      || hit(addr, serial_tx_pkg::IDX_IRQ_STATUS)
      || hit(addr, serial_tx_pkg::IDX_IRQ_MASK);
  endfunction

  logic setup;
  logic wr_fire;
  logic rd_fire;

  assign setup = psel && !penable;
  assign wr_fire = psel && penable && pwrite;
  assign rd_fire = psel && penable && !pwrite;

  // Registers reached by software
  logic [7:0] format_reg, format_next;
  logic [7:0] divisor_reg, divisor_next;
  logic [7:0] control_reg, control_next;
  logic [7:0] tx_hold_reg, tx_hold_next;
  logic tx_empty_reg, tx_empty_next;
  logic [6:0] flags_low_reg, flags_low_next;

  // Clear handshake for the empty flag
  logic armed_reg, armed_next;
  logic rd_empty_reg, rd_empty_next;

  // Bus answer
  logic [31:0] prdata_reg, prdata_next;
  logic err_reg, err_next;

  // Transmitter and interrupt block
  serial_tx_pkg::tx_load_type load;
  serial_tx_pkg::irq_write_type status_wr;
  serial_tx_pkg::irq_write_type mask_wr;
  logic busy;
  logic done;
  logic tx_en;
  logic tx_en_fall;
  logic [serial_tx_pkg::IRQ_WIDTH-1:0] events;
  logic [serial_tx_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [serial_tx_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic set_empty;

  assign tx_en = control_reg[serial_tx_pkg::CTRL_TX_EN_BIT];
  assign tx_en_fall = tx_en && !control_next[serial_tx_pkg::CTRL_TX_EN_BIT];

  // Hand the held byte over only while enabled and the shifter is free
  always_comb begin
    load.valid = tx_en && !tx_empty_reg && !busy;
    load.data = tx_hold_reg;
  end

  // Either way of freeing the holding register
  assign set_empty = load.valid
    || (tx_en_fall && !tx_empty_reg);

  tx_shifter u_shifter (
    .pclk(pclk),
    .presetn(presetn),
    .load(load),
    .divisor(divisor_reg),
    .busy(busy),
    .done(done),
    .txd(txd)
  );

  // Configuration and data registers
  always_comb begin
    format_next = format_reg;
    divisor_next = divisor_reg;
    control_next = control_reg;
    tx_hold_next = tx_hold_reg;
    if (wr_fire) begin
      if (hit(paddr, serial_tx_pkg::IDX_FORMAT)) begin
        format_next = pwdata[7:0];
      end
      if (hit(paddr, serial_tx_pkg::IDX_DIVISOR)) begin
        divisor_next = pwdata[7:0];
      end
      if (hit(paddr, serial_tx_pkg::IDX_CONTROL)) begin
        control_next = pwdata[7:0];
      end
      if (hit(paddr, serial_tx_pkg::IDX_TX_HOLD)) begin
        tx_hold_next = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      format_reg <= serial_tx_pkg::FORMAT_RESET;
      divisor_reg <= serial_tx_pkg::DIVISOR_RESET;
      control_reg <= serial_tx_pkg::CONTROL_RESET;
      tx_hold_reg <= serial_tx_pkg::TX_HOLD_RESET;
    end else begin
      format_reg <= format_next;
      divisor_reg <= divisor_next;
      control_reg <= control_next;
      tx_hold_reg <= tx_hold_next;
    end
  end

  // Empty flag and its read-then-write-zero clear
  always_comb begin
    tx_empty_next = tx_empty_reg;
    flags_low_next = flags_low_reg;
    armed_next = armed_reg;
    if (rd_fire && hit(paddr, serial_tx_pkg::IDX_FLAGS)) begin
      armed_next = armed_reg || rd_empty_reg;
    end
    if (wr_fire && hit(paddr, serial_tx_pkg::IDX_FLAGS)) begin
      // A written 1 leaves the flag alone
      if (armed_reg && !pwdata[serial_tx_pkg::FLAGS_TX_EMPTY_BIT]) begin
        tx_empty_next = 1'b0;
      end
      // Receive-side flags are never set here; a written 0 keeps them clear
      for (int b = serial_tx_pkg::FLAGS_CLEARABLE_LSB; b < 7; b++) begin
        if (!pwdata[b]) begin
          flags_low_next[b] = 1'b0;
        end
      end
      armed_next = 1'b0;
    end
    // Transmit end follows the flag and the shifter
    flags_low_next[serial_tx_pkg::FLAGS_TX_END_BIT] = tx_empty_next && !busy;
    // Hardware set wins over a clear in the same cycle
    if (set_empty) begin
      tx_empty_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_reg <= 1'b1;
      flags_low_reg <= serial_tx_pkg::FLAGS_LOW_RESET;
      armed_reg <= 1'b0;
    end else begin
      tx_empty_reg <= tx_empty_next;
      flags_low_reg <= flags_low_next;
      armed_reg <= armed_next;
    end
  end

  // Interrupt events and software access to the sticky block
  assign events[serial_tx_pkg::IRQ_EMPTY_BIT] = set_empty && !tx_empty_reg;
  assign events[serial_tx_pkg::IRQ_DONE_BIT] = done;

  always_comb begin
    status_wr.write = wr_fire && hit(paddr, serial_tx_pkg::IDX_IRQ_STATUS);
    status_wr.wdata = pwdata[serial_tx_pkg::IRQ_WIDTH-1:0];
    mask_wr.write = wr_fire && hit(paddr, serial_tx_pkg::IDX_IRQ_MASK);
    mask_wr.wdata = pwdata[serial_tx_pkg::IRQ_WIDTH-1:0];
  end

  irq_sticky u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .events(events),
    .status_wr(status_wr),
    .mask_wr(mask_wr),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // Request is level, not an edge, so a masked-then-enabled flag still fires
  assign tx_empty_irq = tx_empty_reg
    && control_reg[serial_tx_pkg::CTRL_TX_IRQ_EN_BIT];

  // Read data captured in the setup cycle, so the access phase needs no wait
  always_comb begin
    prdata_next = prdata_reg;
    err_next = err_reg;
    rd_empty_next = rd_empty_reg;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      err_next = !mapped(paddr);
      rd_empty_next = 1'b0;
      if (!pwrite) begin
        if (hit(paddr, serial_tx_pkg::IDX_FORMAT)) begin
          prdata_next[7:0] = format_reg;
        end
        if (hit(paddr, serial_tx_pkg::IDX_DIVISOR)) begin
          prdata_next[7:0] = divisor_reg;
        end
        if (hit(paddr, serial_tx_pkg::IDX_CONTROL)) begin
          prdata_next[7:0] = control_reg;
        end
        if (hit(paddr, serial_tx_pkg::IDX_TX_HOLD)) begin
          prdata_next[7:0] = tx_hold_reg;
        end
        if (hit(paddr, serial_tx_pkg::IDX_FLAGS)) begin
          prdata_next[7:0] = {tx_empty_reg, flags_low_reg};
          rd_empty_next = tx_empty_reg;
        end
        if (hit(paddr, serial_tx_pkg::IDX_IRQ_STATUS)) begin
          prdata_next[serial_tx_pkg::IRQ_WIDTH-1:0] = irq_status;
        end
        if (hit(paddr, serial_tx_pkg::IDX_IRQ_MASK)) begin
          prdata_next[serial_tx_pkg::IRQ_WIDTH-1:0] = irq_mask;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      rd_empty_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      err_reg <= err_next;
      rd_empty_reg <= rd_empty_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_reg;

endmodule // serial_tx_empty_status

// [hw/serial_tx_pkg.sv]
// How it works
// - Moving the held byte into the transmit shift register sets the empty flag.
// - Clearing the transmitter enable while the empty flag is 0 sets the flag.
// - The empty flag clears only when a write of 0 follows a read that returned it as 1.
// - Status bits 7 to 3 take only a written 0 as a clear; a written 1 changes nothing.
// - The transmit interrupt enable blocks tx_empty_irq at 0 and passes it at 1; the sticky empty status bit and irq do not depend on it.
package serial_tx_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_FORMAT = 10'h0d8;
  localparam logic [9:0] IDX_DIVISOR = 10'h0d9;
  localparam logic [9:0] IDX_CONTROL = 10'h0da;
  localparam logic [9:0] IDX_TX_HOLD = 10'h0db;
  localparam logic [9:0] IDX_FLAGS = 10'h0dc;
  localparam logic [9:0] IDX_RX_HOLD = 10'h0dd;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0e0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0e1;

  // Control fields
  localparam int CTRL_TX_IRQ_EN_BIT = 7;
  localparam int CTRL_TX_EN_BIT = 5;

  // Status fields
  localparam int FLAGS_TX_EMPTY_BIT = 7;
  localparam int FLAGS_CLEARABLE_LSB = 3;
  localparam int FLAGS_TX_END_BIT = 2;

  // Event bits of the sticky interrupt status
  localparam int IRQ_WIDTH = 2;
  localparam int IRQ_EMPTY_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;

  // Reset values
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'hff;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] TX_HOLD_RESET = 8'hff;
  localparam logic [6:0] FLAGS_LOW_RESET = 7'h04;
  localparam logic IRQ_MASK_RESET = 1'b0;

  // Frame: one start bit, eight data bits, one stop bit
  localparam logic [3:0] FRAME_BITS = 4'ha;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tx_load_type;

  typedef struct packed {
    logic write;
    logic [IRQ_WIDTH-1:0] wdata;
  } irq_write_type;

endpackage

// [hw/tx_shifter.sv]
`timescale 1ns/10ps
module tx_shifter (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire serial_tx_pkg::tx_load_type load, // Byte from holding register
  input wire logic [7:0] divisor, // Bit time is divisor plus one cycles
  output logic busy, // Frame in progress
  output logic done, // Pulse at end of stop bit
  output logic txd // Serial output, idles high
);
  logic [9:0] frame_reg, frame_next;
  logic [3:0] bits_reg, bits_next;
  logic [7:0] tick_reg, tick_next;
  logic done_reg, done_next;

  always_comb begin
    frame_next = frame_reg;
    bits_next = bits_reg;
    tick_next = tick_reg;
    done_next = 1'b0;
    if (bits_reg == 4'h0) begin
      if (load.valid) begin
        frame_next = {1'b1, load.data, 1'b0};
        bits_next = serial_tx_pkg::FRAME_BITS;
        tick_next = divisor;
      end
    end else if (tick_reg != 8'h00) begin
      tick_next = tick_reg - 8'h01;
    end else begin
      frame_next = {1'b1, frame_reg[9:1]};
      bits_next = bits_reg - 4'h1;
      tick_next = divisor;
      done_next = (bits_reg == 4'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_reg <= 10'h3ff;
      bits_reg <= 4'h0;
      tick_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      bits_reg <= bits_next;
      tick_reg <= tick_next;
      done_reg <= done_next;
    end
  end

  assign busy = (bits_reg != 4'h0);
  assign done = done_reg;
  assign txd = frame_reg[0];
endmodule // tx_shifter

// [hw/irq_sticky.sv]
`timescale 1ns/10ps
module irq_sticky (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [serial_tx_pkg::IRQ_WIDTH-1:0] events, // One-cycle event pulses
  input wire serial_tx_pkg::irq_write_type status_wr, // Write one to clear
  input wire serial_tx_pkg::irq_write_type mask_wr, // Mask register write
  output logic [serial_tx_pkg::IRQ_WIDTH-1:0] status, // Sticky event bits
  output logic [serial_tx_pkg::IRQ_WIDTH-1:0] mask, // Enables per bit
  output logic irq // Level interrupt
);
  logic [serial_tx_pkg::IRQ_WIDTH-1:0] status_reg, status_next;
  logic [serial_tx_pkg::IRQ_WIDTH-1:0] mask_reg, mask_next;

  genvar i;
  generate
    for (i = 0; i < serial_tx_pkg::IRQ_WIDTH; i++) begin : g_bit
      // Set wins over a clear in the same cycle
      always_comb begin
        status_next[i] = status_reg[i];
        mask_next[i] = mask_reg[i];
        if (status_wr.write && status_wr.wdata[i]) begin
          status_next[i] = 1'b0;
        end
        if (events[i]) begin
          status_next[i] = 1'b1;
        end
        if (mask_wr.write) begin
          mask_next[i] = mask_wr.wdata[i];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          status_reg[i] <= 1'b0;
          mask_reg[i] <= serial_tx_pkg::IRQ_MASK_RESET;
        end else begin
          status_reg[i] <= status_next[i];
          mask_reg[i] <= mask_next[i];
        end
      end
    end
  endgenerate

  assign status = status_reg;
  assign mask = mask_reg;
  assign irq = |(status_reg & mask_reg);
endmodule // irq_sticky

// [tb/serial_tx_empty_status_chk.sv]
`timescale 1ns/10ps
module serial_tx_empty_status_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic txd, // Serial line
  input wire logic tx_empty_irq, // Empty request
  input wire logic irq // Sticky interrupt
);
  logic [7:0] ctl_reg;
  logic armed_reg;
  logic [7:0] div_reg;
  logic txd_q;
  logic [11:0] frame_cnt;
  logic wr_div;
  logic acc, wr_ctl, wr_flags, rd_flags, mapped;
  assign acc = psel && penable && pready;
  assign wr_ctl = acc && pwrite && paddr == 12'h368;
  assign wr_div = acc && pwrite && paddr == 12'h364;
  assign wr_flags = acc && pwrite && paddr == 12'h370;
  assign rd_flags = acc && !pwrite && paddr == 12'h370;
  assign mapped = paddr[1:0] == 2'h0 && ((paddr[11:2] >= 10'h0d8 && paddr[11:2] <= 10'h0dd)
    || paddr[11:2] == 10'h0e0 || paddr[11:2] == 10'h0e1);
  // Shadow of control and of the read that arms a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= 8'h00;
      armed_reg <= 1'b0;
      div_reg <= 8'hff;
      txd_q <= 1'b1;
      frame_cnt <= 12'h000;
    end else begin
      if (wr_ctl) ctl_reg <= pwdata[7:0];
      if (wr_div) div_reg <= pwdata[7:0];
      txd_q <= txd;
      // Data bits also fall; only a fall with the count at zero is a start bit
      if (frame_cnt != 12'h000) frame_cnt <= frame_cnt - 12'h001;
      else if (txd_q && !txd) frame_cnt <= 12'h009 * ({4'h0, div_reg} + 12'h001);
      if (wr_flags) armed_reg <= 1'b0;
      else if (rd_flags) armed_reg <= prdata[7];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_irq_blocked: assert property (!ctl_reg[7] |-> !tx_empty_irq)
    else $error("empty request while blocked");
  a_read_agrees: assert property (rd_flags && prdata[7] && ctl_reg[7] |-> tx_empty_irq)
    else $error("empty request low while flag reads one");
  a_clear_cause: assert property ($fell(tx_empty_irq) && ctl_reg[7] && $past(ctl_reg[7])
    |-> $past(wr_flags && !pwdata[7] && armed_reg))
    else $error("flag cleared without read then write zero");
  a_unarmed_keeps: assert property (wr_flags && !armed_reg && tx_empty_irq |=> tx_empty_irq)
    else $error("flag cleared without a prior read");
  a_one_keeps: assert property (wr_flags && pwdata[7] && tx_empty_irq |=> tx_empty_irq)
    else $error("written one cleared the flag");
  a_disable_sets: assert property (wr_ctl && ctl_reg[5] && !pwdata[5] && pwdata[7]
    |=> tx_empty_irq)
    else $error("disabling transmitter left flag clear");
  a_load_sets: assert property ($fell(txd) && frame_cnt == 12'h000 && ctl_reg[7]
    |-> tx_empty_irq)
    else $error("frame started with flag clear");
  a_ready_now: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response does not match address map");
  c_flag_clear: cover property ($fell(tx_empty_irq));
  c_frame_start: cover property ($fell(txd));
  c_bad_addr: cover property (acc && pslverr);
endmodule // serial_tx_empty_status_chk

bind serial_tx_empty_status serial_tx_empty_status_chk u_serial_tx_empty_status_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txd(txd), .tx_empty_irq(tx_empty_irq), .irq(irq));

// [tb/serial_tx_empty_status_test.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module serial_tx_empty_status_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, txd, tx_empty_irq, irq;
  logic [31:0] q;
  logic e;
  logic [9:0] frame;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  logic [11:0] ra [7] = '{12'h360, 12'h364, 12'h368, 12'h36c, 12'h370, 12'h374, 12'h384};
  logic [7:0] rv [7] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h84, 8'h00, 8'h00};
  always #5 pclk = ~pclk;
  serial_tx_empty_status u_serial_tx_empty_status (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
    .tx_empty_irq(tx_empty_irq), .irq(irq));
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] ex);
    xfer(1'b0, a, 8'h00);
    `CHK("read data", ex, q[7:0])
  endtask
  task automatic see(input logic ex);
    #1;
    `CHK("tx_empty_irq", ex, tx_empty_irq)
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Whole run is under a thousand cycles; the ceiling leaves ample slack
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("idle line", 1'b1, txd)
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    xfer(1'b0, 12'h378, 8'h00);
    `CHK("unmapped error", 1'b1, e)
    `CHK("unmapped read", 32'h0, q)
    xfer(1'b0, 12'h361, 8'h00);
    `CHK("misaligned read", 32'h0, q)
    `CHK("misaligned error", 1'b1, e)
    xfer(1'b1, 12'h364, 8'h03);
    xfer(1'b1, 12'h368, 8'h80);
    see(1'b1);
    xfer(1'b1, 12'h368, 8'h00);
    see(1'b0);
    xfer(1'b1, 12'h368, 8'h80);
    xfer(1'b1, 12'h370, 8'hf8);
    see(1'b1);
    xfer(1'b1, 12'h370, 8'h00);
    see(1'b1);
    rd(12'h370, 8'h84);
    xfer(1'b1, 12'h370, 8'h78);
    see(1'b0);
    rd(12'h370, 8'h00);
    xfer(1'b1, 12'h36c, 8'h5a);
    xfer(1'b1, 12'h368, 8'ha0);
    @(posedge pclk);
    see(1'b1);
    for (int i = 0; i < 8 && txd !== 1'b0; i++) @(posedge pclk) #1;
    #20;
    for (int i = 0; i < 10; i++) begin
      frame[i] = txd;
      #40;
    end
    `CHK("frame", {1'b1, 8'h5a, 1'b0}, frame)
    xfer(1'b1, 12'h36c, 8'h3c);
    rd(12'h370, 8'h84);
    xfer(1'b1, 12'h370, 8'h00);
    rd(12'h370, 8'h80);
    xfer(1'b1, 12'h370, 8'h00);
    see(1'b0);
    xfer(1'b1, 12'h368, 8'h80);
    see(1'b1);
    #600;
    rd(12'h380, 8'h03);
    `CHK("irq masked", 1'b0, irq)
    xfer(1'b1, 12'h384, 8'h01);
    #1;
    `CHK("irq raised", 1'b1, irq)
    xfer(1'b1, 12'h380, 8'h01);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    rd(12'h380, 8'h02);
    rd(12'h36c, 8'h3c);
    xfer(1'b1, 12'h374, 8'hff);
    rd(12'h374, 8'h00);
    give_verdict();
  end
endmodule // serial_tx_empty_status_test
